// ---- rtl/ncss_top.v ----
// Behaviour
// - Safety and mode functions come from terminals only
// - Run, brake, V/F follow operation source
// - Multi-speed and PID follow speed source only
// - Terminal-4 select combined when speed source external
// - Output stop combined/terminal; interlock in mode 7
// - Each function: terminal, comms, combined or invalid
// - Run-time source writes allowed when write setting 2
// - Old sources stay in force until stopped
// - Source switch steers start and speed sources
// - Code 67 on any terminal assigns switch
// - Switch assigned and off forces terminal sources
// - Otherwise, in network mode, sources follow the two source settings
// - Switch state change applied only while stopped
// - Comms reset always ignored, whatever the switch state
`timescale 1ns/1ps
`default_nettype none
`include "ncss_regs.vh"

module ncss_top (
  input wire i_clk, // 200 MHz control clock
  input wire i_sys_rst, // Synchronous reset, high
  input wire [6:0] i_term, // Control terminal pins
  input wire [15:0] i_comms_cmd, // Comms commands, per function bit
  input wire i_running, // Drive running, same clock
  input wire i_net_mode, // Network operation mode, same clock
  output reg [15:0] o_func_active, // Accepted function commands
  output reg o_op_src_eff, // Effective op source, 1 = terminal
  output reg [1:0] o_spd_src_eff, // Effective speed source
  input wire [7:0] i_s_axi_awaddr, // AXI write address
  input wire i_s_axi_awvalid, // AXI write address valid
  output reg o_s_axi_awready, // AXI write address ready
  input wire [31:0] i_s_axi_wdata, // AXI write data
  input wire [3:0] i_s_axi_wstrb, // AXI write strobes
  input wire i_s_axi_wvalid, // AXI write data valid
  output reg o_s_axi_wready, // AXI write data ready
  output reg [1:0] o_s_axi_bresp, // AXI write response
  output reg o_s_axi_bvalid, // AXI write response valid
  input wire i_s_axi_bready, // AXI write response ready
  input wire [7:0] i_s_axi_araddr, // AXI read address
  input wire i_s_axi_arvalid, // AXI read address valid
  output reg o_s_axi_arready, // AXI read address ready
  output reg [31:0] o_s_axi_rdata, // AXI read data
  output reg [1:0] o_s_axi_rresp, // AXI read response
  output reg o_s_axi_rvalid, // AXI read valid
  input wire i_s_axi_rready // AXI read ready
);

  // ********************
  // Functions
  // ********************
  function [6:0] code_of;
    input [3:0] ix;
    begin
      case (ix)
        `NCSS_IX_TERM4: code_of = `NCSS_FC_TERM4;
        `NCSS_IX_THERMAL: code_of = `NCSS_FC_THERMAL;
        `NCSS_IX_SPEED15: code_of = `NCSS_FC_SPEED15;
        `NCSS_IX_RUN_EN: code_of = `NCSS_FC_RUN_EN;
        `NCSS_IX_PU_IL: code_of = `NCSS_FC_PU_IL;
        `NCSS_IX_PID: code_of = `NCSS_FC_PID;
        `NCSS_IX_BRAKE: code_of = `NCSS_FC_BRAKE;
        `NCSS_IX_PU_EXT: code_of = `NCSS_FC_PU_EXT;
        `NCSS_IX_VF: code_of = `NCSS_FC_VF;
        `NCSS_IX_OUT_STOP: code_of = `NCSS_FC_OUT_STOP;
        `NCSS_IX_FWD: code_of = `NCSS_FC_FWD;
        `NCSS_IX_REV: code_of = `NCSS_FC_REV;
        `NCSS_IX_CLEAR: code_of = `NCSS_FC_CLEAR;
        `NCSS_IX_PU_COMMS: code_of = `NCSS_FC_PU_COMMS;
        `NCSS_IX_EXT_COMMS: code_of = `NCSS_FC_EXT_COMMS;
        default: code_of = `NCSS_FC_SRC_SW;
      endcase
    end
  endfunction

  // Source for one function given effective settings
  function [1:0] src_of;
    input [3:0] ix;
    input op;
    input [1:0] spd;
    input mode7;
    begin
      case (ix)
        `NCSS_IX_FWD, `NCSS_IX_REV, `NCSS_IX_BRAKE, `NCSS_IX_VF: begin
          src_of = op ? `NCSS_SRC_TERM : `NCSS_SRC_COMM;
        end
        `NCSS_IX_SPEED15, `NCSS_IX_PID: src_of = (spd == 2'h0) ? `NCSS_SRC_COMM : `NCSS_SRC_TERM;
        `NCSS_IX_TERM4: src_of = (spd == 2'h0) ? `NCSS_SRC_NONE : `NCSS_SRC_BOTH;
        `NCSS_IX_OUT_STOP: src_of = mode7 ? `NCSS_SRC_NONE : (op ? `NCSS_SRC_TERM : `NCSS_SRC_BOTH);
        default: src_of = `NCSS_SRC_TERM;
      endcase
    end
  endfunction

  // Maps an address to a terminal slot, 4'hF when not a slot
  function [3:0] slot_of;
    input [7:0] addr;
    reg [7:0] rel;
    begin
      rel = addr - `NCSS_OFF_TFS_BASE;
      if (addr >= `NCSS_OFF_TFS_BASE && addr <= `NCSS_OFF_TFS_LAST && addr[1:0] == 2'h0) begin
        slot_of = {1'b0, rel[4:2]};
      end else begin
        slot_of = 4'hF;
      end
    end
  endfunction

  // ********************
  // Terminal synchronisers
  // ********************
  reg [6:0] term_s1;
  reg [6:0] term_s2;
  reg [6:0] term_s3;
  reg [6:0] term_lvl;

  // A change counts only once stages two and three agree
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      term_s1 <= 7'h00;
      term_s2 <= 7'h00;
      term_s3 <= 7'h00;
      term_lvl <= 7'h00;
    end else begin
      term_s1 <= i_term;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
      term_lvl <= (term_s2 & term_s3) | (term_lvl & (term_s2 | term_s3));
    end
  end

  // ********************
  // Settings
  // ********************
  reg op_src;
  reg [1:0] spd_src;
  reg [1:0] param_wr;
  reg [3:0] op_mode;
  reg [6:0] tfs [0:6];
  reg lat_op;
  reg [1:0] lat_spd;
  reg lat_sw;

  // ********************
  // Function routing
  // ********************
  reg [15:0] term_hit;
  reg sw_assigned;
  reg il_assigned;
  reg eff_op;
  reg [1:0] eff_spd;
  reg mode7;
  reg [15:0] next_active;
  integer fi;
  integer ti;
  integer ai;
  integer ri;

  always @* begin
    term_hit = 16'h0000;
    sw_assigned = 1'b0;
    il_assigned = 1'b0;
    for (ti = 0; ti < `NCSS_NUM_TERM; ti = ti + 1) begin
      if (tfs[ti] == `NCSS_FC_SRC_SW) begin
        sw_assigned = 1'b1;
      end
      if (tfs[ti] == `NCSS_FC_PU_IL) begin
        il_assigned = 1'b1;
      end
      for (fi = 0; fi < `NCSS_NUM_FUNC; fi = fi + 1) begin
        if (tfs[ti] == code_of(fi[3:0]) && term_lvl[ti]) begin
          term_hit[fi] = 1'b1;
        end
      end
    end
  end

  // Outside network mode terminal sources are forced; terminal-4 select still takes comms too
  always @* begin
    if (!i_net_mode || (sw_assigned && !lat_sw)) begin
      eff_op = 1'b1;
      eff_spd = 2'h1;
    end else begin
      eff_op = lat_op;
      eff_spd = lat_spd;
    end
    mode7 = (op_mode == `NCSS_OPMODE_PU_IL);
    next_active = 16'h0000;
    for (ai = 0; ai < `NCSS_NUM_FUNC; ai = ai + 1) begin
      next_active[ai] = (src_of(ai[3:0], eff_op, eff_spd, mode7) == `NCSS_SRC_BOTH) ?
                        (term_hit[ai] | i_comms_cmd[ai]) :
                        (src_of(ai[3:0], eff_op, eff_spd, mode7) == `NCSS_SRC_TERM) ? term_hit[ai] :
                        (src_of(ai[3:0], eff_op, eff_spd, mode7) == `NCSS_SRC_COMM) ? i_comms_cmd[ai] :
                        1'b0;
    end
    if (mode7 && !il_assigned && term_hit[`NCSS_IX_OUT_STOP]) begin
      next_active[`NCSS_IX_PU_IL] = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_func_active <= 16'h0000;
      o_op_src_eff <= 1'b1;
      o_spd_src_eff <= 2'h1;
    end else begin
      o_func_active <= next_active;
      o_op_src_eff <= eff_op;
      o_spd_src_eff <= eff_spd;
    end
  end

  // ********************
  // Stop-time latching
  // ********************
  // Source and switch changes during a run wait for the stop
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      lat_op <= `NCSS_RST_OP_SRC;
      lat_spd <= `NCSS_RST_SPD_SRC;
      lat_sw <= 1'b0;
    end else if (!i_running) begin
      lat_op <= op_src;
      lat_spd <= spd_src;
      lat_sw <= term_hit[`NCSS_IX_SRC_SW];
    end
  end

  // ********************
  // AXI4-Lite write
  // ********************
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [3:0] wslot;
  reg src_locked;

  always @* begin
    wslot = slot_of(aw_addr);
    src_locked = i_running && (param_wr != `NCSS_PW_RUN_WRITE);
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `NCSS_RESP_OKAY;
      op_src <= `NCSS_RST_OP_SRC;
      spd_src <= `NCSS_RST_SPD_SRC;
      param_wr <= `NCSS_RST_PARAM_WR;
      op_mode <= `NCSS_RST_OP_MODE;
      for (ri = 0; ri < `NCSS_NUM_TERM; ri = ri + 1) begin
        tfs[ri] <= `NCSS_RST_TFS;
      end
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_addr <= i_s_axi_awaddr;
        aw_got <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
        w_got <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !o_s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= `NCSS_RESP_OKAY;
        // All fields sit in byte lane 0
        if (aw_addr == `NCSS_OFF_OP_SRC || aw_addr == `NCSS_OFF_SPD_SRC) begin
          if (src_locked) begin
            o_s_axi_bresp <= `NCSS_RESP_SLVERR;
          end else if (w_strb[0] && aw_addr == `NCSS_OFF_OP_SRC) begin
            op_src <= w_data[0];
          end else if (w_strb[0]) begin
            spd_src <= w_data[1:0];
          end
        end else if (aw_addr == `NCSS_OFF_PARAM_WR) begin
          if (w_strb[0]) begin
            param_wr <= w_data[1:0];
          end
        end else if (aw_addr == `NCSS_OFF_OP_MODE) begin
          if (w_strb[0]) begin
            op_mode <= w_data[3:0];
          end
        end else if (wslot != 4'hF) begin
          if (w_strb[0]) begin
            tfs[wslot[2:0]] <= w_data[6:0];
          end
        end else if (aw_addr == `NCSS_OFF_STATUS || aw_addr == `NCSS_OFF_ACTIVE) begin
          o_s_axi_bresp <= `NCSS_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `NCSS_RESP_SLVERR;
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // ********************
  // AXI4-Lite read
  // ********************
  reg [31:0] rd_data;
  reg rd_err;
  reg [3:0] rslot;

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    rslot = slot_of(i_s_axi_araddr);
    if (i_s_axi_araddr == `NCSS_OFF_OP_SRC) begin
      rd_data[0] = op_src;
    end else if (i_s_axi_araddr == `NCSS_OFF_SPD_SRC) begin
      rd_data[1:0] = spd_src;
    end else if (i_s_axi_araddr == `NCSS_OFF_PARAM_WR) begin
      rd_data[1:0] = param_wr;
    end else if (i_s_axi_araddr == `NCSS_OFF_OP_MODE) begin
      rd_data[3:0] = op_mode;
    end else if (i_s_axi_araddr == `NCSS_OFF_STATUS) begin
      rd_data[5:0] = {il_assigned, sw_assigned, lat_sw, o_spd_src_eff, o_op_src_eff};
    end else if (i_s_axi_araddr == `NCSS_OFF_ACTIVE) begin
      rd_data[15:0] = o_func_active;
    end else if (rslot != 4'hF) begin
      rd_data[6:0] = tfs[rslot[2:0]];
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `NCSS_RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_data;
        o_s_axi_rresp <= rd_err ? `NCSS_RESP_SLVERR : `NCSS_RESP_OKAY;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ncss_regs.vh ----
`ifndef NCSS_REGS_VH
`define NCSS_REGS_VH

// ********************
// Register offsets
// ********************
`define NCSS_OFF_OP_SRC 8'h00
`define NCSS_OFF_SPD_SRC 8'h04
`define NCSS_OFF_PARAM_WR 8'h08
`define NCSS_OFF_OP_MODE 8'h0C
`define NCSS_OFF_STATUS 8'h10
`define NCSS_OFF_ACTIVE 8'h14
`define NCSS_OFF_TFS_BASE 8'h20
`define NCSS_OFF_TFS_LAST 8'h38

// ********************
// Reset values
// ********************
`define NCSS_RST_OP_SRC 1'h0
`define NCSS_RST_SPD_SRC 2'h0
`define NCSS_RST_PARAM_WR 2'h0
`define NCSS_RST_OP_MODE 4'h0
`define NCSS_RST_TFS 7'h00

// ********************
// Setting values
// ********************
`define NCSS_PW_RUN_WRITE 2'h2
`define NCSS_OPMODE_PU_IL 4'h7
`define NCSS_SRC_NONE 2'h0
`define NCSS_SRC_TERM 2'h1
`define NCSS_SRC_COMM 2'h2
`define NCSS_SRC_BOTH 2'h3
`define NCSS_RESP_OKAY 2'h0
`define NCSS_RESP_SLVERR 2'h2

// ********************
// Function codes
// ********************
`define NCSS_FC_TERM4 7'h04
`define NCSS_FC_THERMAL 7'h07
`define NCSS_FC_SPEED15 7'h08
`define NCSS_FC_RUN_EN 7'h0A
`define NCSS_FC_PU_IL 7'h0C
`define NCSS_FC_PID 7'h0E
`define NCSS_FC_BRAKE 7'h0F
`define NCSS_FC_PU_EXT 7'h10
`define NCSS_FC_VF 7'h12
`define NCSS_FC_OUT_STOP 7'h18
`define NCSS_FC_FWD 7'h3C
`define NCSS_FC_REV 7'h3D
`define NCSS_FC_CLEAR 7'h3E
`define NCSS_FC_PU_COMMS 7'h41
`define NCSS_FC_EXT_COMMS 7'h42
`define NCSS_FC_SRC_SW 7'h43

// ********************
// Function bit positions
// ********************
`define NCSS_IX_TERM4 0
`define NCSS_IX_THERMAL 1
`define NCSS_IX_SPEED15 2
`define NCSS_IX_RUN_EN 3
`define NCSS_IX_PU_IL 4
`define NCSS_IX_PID 5
`define NCSS_IX_BRAKE 6
`define NCSS_IX_PU_EXT 7
`define NCSS_IX_VF 8
`define NCSS_IX_OUT_STOP 9
`define NCSS_IX_FWD 10
`define NCSS_IX_REV 11
`define NCSS_IX_CLEAR 12
`define NCSS_IX_PU_COMMS 13
`define NCSS_IX_EXT_COMMS 14
`define NCSS_IX_SRC_SW 15

`define NCSS_NUM_FUNC 16
`define NCSS_NUM_TERM 7

`endif

// ---- verif/ncss_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ncss_far_model (
  input wire logic i_clk, // Control clock
  input wire logic [6:0] i_want_term, // Pin levels asked by bench
  input wire logic [15:0] i_want_comms, // Link word asked by bench
  output logic [6:0] o_term, // Terminal pins
  output logic [15:0] o_comms // Link command word
);
  // One edge late, like a frame landing after the request
  always @(posedge i_clk) begin
    o_term <= i_want_term;
    o_comms <= i_want_comms;
  end
endmodule
`default_nettype wire

// ---- verif/ncss_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ncss_asserts (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic [6:0] i_term, // Pins
  input wire logic [15:0] i_comms_cmd, // Link word
  input wire logic i_running, // Running
  input wire logic i_net_mode, // Network mode
  input wire logic [15:0] o_func_active, // Accepted functions
  input wire logic o_op_src_eff, // Op source
  input wire logic [1:0] o_spd_src_eff, // Speed source
  input wire logic i_s_axi_arvalid, // AR valid
  input wire logic o_s_axi_arready, // AR ready
  input wire logic o_s_axi_rvalid, // R valid
  input wire logic [31:0] o_s_axi_rdata, // R data
  input wire logic i_s_axi_rready, // R ready
  input wire logic o_s_axi_bvalid, // B valid
  input wire logic [1:0] o_s_axi_bresp, // B resp
  input wire logic i_s_axi_bready // B ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Pins idle long enough to pass the sync flops
  logic [2:0] quiet;
  always @(posedge i_clk) begin
    if (i_sys_rst || i_term != 7'h00) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  property p_term_only;
    quiet == 3'h7 |-> (o_func_active & 16'hF09A) == 16'h0000;
  endproperty
  a_term_only: assert property (p_term_only) else $error("terminal-only function active");
  property p_clear;
    quiet == 3'h7 && i_comms_cmd[12] |=> !o_func_active[12];
  endproperty
  a_clear: assert property (p_clear) else $error("link clear accepted");
  property p_op_comms;
    !o_op_src_eff && !$past(o_op_src_eff) |-> o_func_active[10] == $past(i_comms_cmd[10]);
  endproperty
  a_op_comms: assert property (p_op_comms) else $error("forward run not from link");
  property p_spd_comms;
    o_spd_src_eff == 2'h0 && $past(o_spd_src_eff) == 2'h0 |-> o_func_active[2] == $past(i_comms_cmd[2]);
  endproperty
  a_spd_comms: assert property (p_spd_comms) else $error("speed select not from link");
  property p_term4;
    quiet == 3'h7 && o_spd_src_eff == 2'h0 && $past(o_spd_src_eff) == 2'h0 |-> !o_func_active[0];
  endproperty
  a_term4: assert property (p_term4) else $error("invalid terminal-4 select active");
  property p_hold;
    $past(i_running) && i_net_mode && $past(i_net_mode) && !$past(i_sys_rst)
      && !$past(i_sys_rst, 2) |-> $stable(o_op_src_eff) && $stable(o_spd_src_eff);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed while running");
  property p_net;
    !i_net_mode |=> o_op_src_eff && o_spd_src_eff == 2'h1;
  endproperty
  a_net: assert property (p_net) else $error("terminal source not forced");
  property p_bhold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rlat;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_fwd: cover property (o_func_active[10] && !o_op_src_eff);
  c_run: cover property (i_running && o_op_src_eff);
  c_err: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule
bind ncss_top ncss_asserts ncss_asserts_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_term(i_term),
  .i_comms_cmd(i_comms_cmd), .i_running(i_running), .i_net_mode(i_net_mode), .o_func_active(o_func_active),
  .o_op_src_eff(o_op_src_eff), .o_spd_src_eff(o_spd_src_eff), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_rdata(o_s_axi_rdata),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_bresp(o_s_axi_bresp),
  .i_s_axi_bready(i_s_axi_bready));
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ncss_regs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic running = 1'b0;
  logic net_mode = 1'b1;
  logic [6:0] want_term = 7'h00;
  logic [15:0] want_comms = 16'h0000;
  logic [6:0] term;
  logic [15:0] comms;
  logic [15:0] active;
  logic op_eff;
  logic [1:0] spd_eff;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_fail = 0;
  int total_checks = 0;
  // Row: op, spd, mode, pins, link all-on flag, expected functions
  logic [39:0] rows [9] = '{40'h000_00_1_0F64, 40'h000_7F_0_1202, 40'h110_7F_0_1623, 40'h120_00_1_0001,
    40'h030_7F_0_1223, 40'h010_00_1_0F41, 40'h100_00_1_0024, 40'h007_7F_0_1012, 40'h007_00_1_0D64};
  logic [6:0] codes [6] = '{`NCSS_FC_THERMAL, `NCSS_FC_FWD, `NCSS_FC_PID, `NCSS_FC_TERM4, `NCSS_FC_OUT_STOP,
    `NCSS_FC_CLEAR};
  always #2.5 clk = ~clk;
  ncss_far_model ncss_far_model_inst (.i_clk(clk), .i_want_term(want_term), .i_want_comms(want_comms),
    .o_term(term), .o_comms(comms));
  ncss_top ncss_top_inst (.i_clk(clk), .i_sys_rst(rst), .i_term(term), .i_comms_cmd(comms),
    .i_running(running), .i_net_mode(net_mode), .o_func_active(active), .o_op_src_eff(op_eff),
    .o_spd_src_eff(spd_eff), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Ready raised late on purpose so the slave must hold its answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
  endtask
  task automatic settle(input logic [6:0] t, input logic [15:0] c);
    want_term <= t;
    want_comms <= c;
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(`NCSS_OFF_PARAM_WR, 32'h0, `NCSS_RESP_OKAY);
    axi_rd(`NCSS_OFF_TFS_LAST, 32'h0, `NCSS_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `NCSS_RESP_SLVERR);
    axi_wr(`NCSS_OFF_STATUS, 32'hFF, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_OP_MODE, 32'h7, 4'h0, `NCSS_RESP_OKAY);
    axi_rd(`NCSS_OFF_OP_MODE, 32'h0, `NCSS_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      axi_wr(`NCSS_OFF_TFS_BASE + 8'(4 * i), {25'h0, codes[i]}, 4'hF, `NCSS_RESP_OKAY);
    end
    $display("test reset and map done");
    foreach (rows[i]) begin
      axi_wr(`NCSS_OFF_OP_SRC, {28'h0, rows[i][39:36]}, 4'hF, `NCSS_RESP_OKAY);
      axi_wr(`NCSS_OFF_SPD_SRC, {28'h0, rows[i][35:32]}, 4'hF, `NCSS_RESP_OKAY);
      axi_wr(`NCSS_OFF_OP_MODE, {28'h0, rows[i][31:28]}, 4'hF, `NCSS_RESP_OKAY);
      settle(rows[i][26:20], {16{rows[i][16]}});
      check(active, rows[i][15:0]);
      check({spd_eff, op_eff}, {rows[i][33:32], rows[i][36]});
      axi_rd(`NCSS_OFF_ACTIVE, {16'h0, rows[i][15:0]}, `NCSS_RESP_OKAY);
    end
    $display("test source table done");
    axi_wr(`NCSS_OFF_OP_MODE, 32'h0, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_OP_SRC, 32'h0, 4'hF, `NCSS_RESP_OKAY);
    settle(7'h00, 16'hFFFF);
    running <= 1'b1;
    axi_wr(`NCSS_OFF_OP_SRC, 32'h1, 4'hF, `NCSS_RESP_SLVERR);
    axi_rd(`NCSS_OFF_OP_SRC, 32'h0, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_PARAM_WR, {30'h0, `NCSS_PW_RUN_WRITE}, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_OP_SRC, 32'h1, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_SPD_SRC, 32'h2, 4'hF, `NCSS_RESP_OKAY);
    settle(7'h00, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h0);
    check(active, 16'h0F64);
    running <= 1'b0;
    settle(7'h00, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h5);
    check(active, 16'h0001);
    $display("test run-time write done");
    axi_wr(`NCSS_OFF_OP_SRC, 32'h0, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_SPD_SRC, 32'h0, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_TFS_LAST, {25'h0, `NCSS_FC_SRC_SW}, 4'hF, `NCSS_RESP_OKAY);
    settle(7'h00, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h3);
    check(active, 16'h0001);
    running <= 1'b1;
    settle(7'h40, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h3);
    running <= 1'b0;
    settle(7'h40, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h0);
    axi_rd(`NCSS_OFF_STATUS, 32'h18, `NCSS_RESP_OKAY);
    net_mode <= 1'b0;
    settle(7'h40, 16'hFFFF);
    check({spd_eff, op_eff}, 3'h3);
    // Interlock assigned in mode 7: output stop pin must not reach it
    axi_wr(`NCSS_OFF_TFS_LAST, {25'h0, `NCSS_FC_PU_IL}, 4'hF, `NCSS_RESP_OKAY);
    axi_wr(`NCSS_OFF_OP_MODE, 32'h7, 4'hF, `NCSS_RESP_OKAY);
    settle(7'h10, 16'hFFFF);
    check(active, 16'h0001);
    axi_rd(`NCSS_OFF_STATUS, 32'h23, `NCSS_RESP_OKAY);
    $display("test source switch done");
    print_verdict;
  end
endmodule
`default_nettype wire
